// file: core/mbd_pkg.sv
// Purpose: shared types and timing constants for the move/bit/branch decoder
// Assumes: one state is a fixed number of core clock cycles
// Notes: instruction classes are pre-decoded by the prefetch queue
package mbd_pkg;
  localparam int PC_W = 24;
  localparam int DATA_W = 32;
  localparam int OPND_W = 16;
  localparam int CNT_W = 5;
  localparam int CLK_PER_STATE = 2;
  // Extra states on top of the table value
  localparam logic [4:0] TAKEN_EXTRA = 5'h03;
  localparam logic [4:0] IO_RD_EXTRA = 5'h01;
  localparam logic [4:0] SFR_RD_EXTRA = 5'h02;
  localparam logic [4:0] IO_WR_EXTRA = 5'h02;
  localparam logic [4:0] SFR_WR_EXTRA = 5'h03;
  localparam logic [4:0] IO_DEC_EXTRA = 5'h02;
  localparam logic [15:0] UPPER_ONES = 16'hFFFF;
  localparam logic [15:0] UPPER_ZEROS = 16'h0000;

  typedef enum logic [6:0] {
    OP_MV_B, OP_MV_W, OP_MV_D, OP_IMM_B, OP_IMM_W, OP_IMM_DZ, OP_IMM_DO,
    OP_LDS_B, OP_LDS_W, OP_LDS_D, OP_LDL_B, OP_LDL_W, OP_LDL_D,
    OP_LDI_BW, OP_LDI_BD, OP_LDI_WW, OP_LDI_WD,
    OP_STS_B, OP_STS_W, OP_STS_D, OP_STL_B, OP_STL_W, OP_STL_D,
    OP_STI_BW, OP_STI_BD, OP_STI_WW, OP_STI_WD,
    OP_LDX_BW, OP_LDX_WW, OP_LDX_BD,
    OP_CF_CLEAR, OP_CF_SET, OP_CF_INV,
    OP_BIT0_L, OP_BIT0_X, OP_BIT1_L, OP_BIT1_X, OP_BITN_L, OP_BITN_X,
    OP_AND_L, OP_AND_X, OP_ANDN_L, OP_ANDN_X,
    OP_OR_L, OP_OR_X, OP_ORN_L, OP_ORN_X,
    OP_B2C_L, OP_B2C_X, OP_C2B_L, OP_C2B_X,
    OP_BR_ZERO, OP_BR_NZERO, OP_BR_HI_L, OP_BR_HI_X, OP_BR_LO_L, OP_BR_LO_X,
    OP_BR_TC_L, OP_BR_TC_X, OP_BR_CMP, OP_BR_DEC_R, OP_BR_DEC_D
  } mbd_op_t;

  typedef enum logic [1:0] {TGT_MEM, TGT_IO, TGT_SFR} mbd_tgt_t;
  typedef enum logic [1:0] {ADJ_SAME, ADJ_LESS, ADJ_MORE} mbd_adj_t;
  typedef enum logic [1:0] {EX_NONE, EX_BIT_RD, EX_BIT_WR, EX_DEC_IO} mbd_ext_t;

  // One row of the timing table, binary mode figures
  typedef struct packed {
    logic [2:0] bytes;
    logic [3:0] states;
    mbd_adj_t adj;
    logic branch;
    mbd_ext_t ext;
  } mbd_row_t;
endpackage

// file: core/mbd_exec_if.sv
// Purpose: carrier between sequencer, operand unit and state timer
// Assumes: all parties on one clock
// Notes: operand unit is purely combinational
`timescale 1ns/1ns
interface mbd_exec_if;
  import mbd_pkg::*;
  mbd_op_t op;
  logic carry;
  logic bit_in;
  logic [7:0] acc;
  logic [OPND_W-1:0] opnd_a;
  logic [OPND_W-1:0] opnd_b;
  logic cond;
  logic carry_we;
  logic carry_out;
  logic bit_we;
  logic bit_out;
  logic res_we;
  logic [DATA_W-1:0] res;
  logic start;
  logic [CNT_W-1:0] states;
  logic done;
  modport seq (output op, carry, bit_in, acc, opnd_a, opnd_b, start, states,
    input cond, carry_we, carry_out, bit_we, bit_out, res_we, res, done);
  modport alu (input op, carry, bit_in, acc, opnd_a, opnd_b,
    output cond, carry_we, carry_out, bit_we, bit_out, res_we, res);
  modport timer (input start, states, output done);
endinterface

// file: core/mbd_state_timer.sv
// Purpose: counts a number of states, each a fixed number of clocks
// Assumes: start is a one-cycle pulse with states of at least one
// Notes: done pulses once, the clock after the last state ends
`timescale 1ns/1ns
module mbd_state_timer #(
  parameter int CLKS = mbd_pkg::CLK_PER_STATE // Clocks per state
) (
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, active low
  mbd_exec_if.timer t // Start, count and done
);
  import mbd_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] left;
    logic [3:0] phase;
    logic run;
    logic done;
  } mbd_tmr_t;
  mbd_tmr_t s, next_s;

  if (CLKS < 1 || CLKS > 16) begin : g_bad_clks
    $error("CLKS out of range");
  end

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (t.start) begin
      next_s.left = t.states;
      next_s.phase = 4'h0;
      next_s.run = 1'b1;
    end else if (s.run) begin
      next_s.phase = s.phase + 4'h1;
      if (s.phase == 4'(CLKS - 1)) begin
        next_s.phase = 4'h0;
        next_s.left = s.left - 5'h01;
        if (s.left == 5'h01) begin
          next_s.run = 1'b0;
          next_s.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s <= '0;
    else s <= next_s;
  end

  assign t.done = s.done;
endmodule

// file: core/mbd_bit_alu.sv
// Purpose: operand results, carry and branch condition per class
// Assumes: operands are held stable by the sequencer
// Notes: byte compare and decrement use the low eight bits
`timescale 1ns/1ns
module mbd_bit_alu (
  mbd_exec_if.alu x // Operands in, results out
);
  import mbd_pkg::*;
  logic [7:0] dec;

  always_comb begin
    dec = x.opnd_a[7:0] - 8'h01;
    x.cond = 1'b0;
    x.carry_we = 1'b0;
    x.carry_out = x.carry;
    x.bit_we = 1'b0;
    x.bit_out = x.bit_in;
    x.res_we = 1'b0;
    x.res = {UPPER_ZEROS, x.opnd_a};
    unique case (x.op)
      // Upper half filled with zeros or ones
      OP_IMM_DZ: x.res_we = 1'b1;
      OP_IMM_DO: begin
        x.res_we = 1'b1;
        x.res = {UPPER_ONES, x.opnd_a};
      end
      OP_CF_CLEAR: {x.carry_we, x.carry_out} = 2'b10;
      OP_CF_SET: {x.carry_we, x.carry_out} = 2'b11;
      OP_CF_INV: {x.carry_we, x.carry_out} = {1'b1, ~x.carry};
      OP_BIT0_L, OP_BIT0_X: {x.bit_we, x.bit_out} = 2'b10;
      OP_BIT1_L, OP_BIT1_X: {x.bit_we, x.bit_out} = 2'b11;
      OP_BITN_L, OP_BITN_X: {x.bit_we, x.bit_out} = {1'b1, ~x.bit_in};
      OP_AND_L, OP_AND_X: {x.carry_we, x.carry_out} = {1'b1, x.carry & x.bit_in};
      OP_ANDN_L, OP_ANDN_X: {x.carry_we, x.carry_out} = {1'b1, x.carry & ~x.bit_in};
      OP_OR_L, OP_OR_X: {x.carry_we, x.carry_out} = {1'b1, x.carry | x.bit_in};
      OP_ORN_L, OP_ORN_X: {x.carry_we, x.carry_out} = {1'b1, x.carry | ~x.bit_in};
      OP_B2C_L, OP_B2C_X: {x.carry_we, x.carry_out} = {1'b1, x.bit_in};
      OP_C2B_L, OP_C2B_X: {x.bit_we, x.bit_out} = {1'b1, x.carry};
      OP_BR_ZERO: x.cond = (x.acc == 8'h00);
      OP_BR_NZERO: x.cond = (x.acc != 8'h00);
      OP_BR_HI_L, OP_BR_HI_X: x.cond = x.bit_in;
      OP_BR_LO_L, OP_BR_LO_X: x.cond = ~x.bit_in;
      // Clear only when set, then jump
      OP_BR_TC_L, OP_BR_TC_X: begin
        x.cond = x.bit_in;
        x.bit_we = x.bit_in;
        x.bit_out = 1'b0;
      end
      // Carry from less-than, jump on unequal
      OP_BR_CMP: begin
        x.cond = (x.opnd_a[7:0] != x.opnd_b[7:0]);
        x.carry_we = 1'b1;
        x.carry_out = (x.opnd_a[7:0] < x.opnd_b[7:0]);
      end
      OP_BR_DEC_R, OP_BR_DEC_D: begin
        x.cond = (dec != 8'h00);
        x.res_we = 1'b1;
        x.res = {24'h000000, dec};
      end
      default: x.res_we = (x.op <= OP_LDX_BD);
    endcase
  end
endmodule

// file: core/mbd_decoder.sv
// Purpose: length, state timing and effects of move, bit and branch classes
// Assumes: prefetch queue hands over pre-decoded classes and operands
// Notes: the datapath writes results back; this block only times and computes
`timescale 1ns/1ns
// Behaviour
// - Byte and word register moves: 3 bytes 2 states, source 2 bytes 1 state.
// - Doubleword register move: 3 bytes 3 states, source 2 bytes 2 states.
// - Byte immediate 4/3 or 3/2; word immediate 5/3 or 4/2 bytes/states.
// - Doubleword immediate, zero or one extended: 5/5 binary, 4/4 source.
// - Short direct loads 4 bytes: byte 3, word 4, dword 6; source one less.
// - Long direct loads 5 bytes: byte 3, word 4, dword 6; source one less.
// - Indirect loads 4 bytes: 3, 4, 4, 5 states; source one less each.
// - Short direct stores 4 bytes: byte 4, word 5, dword 7; source one less.
// - Long direct stores 5 bytes: byte 4, word 5, dword 7; source one less.
// - Indirect stores 4 bytes: 4, 5, 5, 6 states; source one less each.
// - Displacement loads 5 bytes: 6, 7, 7 states; source one less each.
// - Carry ops 1 byte 1 state; legacy bit 2/2; extended bit 4/4 or 3/3.
// - Carry logic with bit: legacy 2/1; extended 4/3 or 3/2.
// - Carry into bit: legacy 2/2; extended 4/4 or 3/3.
// - Bit reads and bit-test branches: I/O port +1, peripheral register +2.
// - Bit writes: I/O port +2 states, peripheral register +3 states.
// - Branch: PC advances by length, offset added only when condition holds.
// - Zero and legacy bit-test branches take 2 states, 5 when taken; extended bit-test 4/7 binary, 3/6 source.
// - Test-and-clear: legacy 4/7, extended 7/10 binary, 6/9 source.
// - Compare branch sets carry on less-than; 2/5 binary, 3/6 source.
// - Decrement branch: register 2/5 or 3/6; direct 3/6, I/O +2.
// - One state is exactly two core clock cycles.
module mbd_decoder (
  input wire logic clk, // Core clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic src_mode, // 1 selects source encoding
  input wire logic instr_valid, // Class and operands presented
  input wire mbd_pkg::mbd_op_t op_class, // Pre-decoded class
  input wire mbd_pkg::mbd_tgt_t target_kind, // Bit or direct operand space
  input wire logic [mbd_pkg::PC_W-1:0] pc_in, // Address of this instruction
  input wire logic [7:0] rel_in, // Signed relative offset
  input wire logic [7:0] acc_in, // Main operand register
  input wire logic [mbd_pkg::OPND_W-1:0] opnd_a, // First source operand
  input wire logic [mbd_pkg::OPND_W-1:0] opnd_b, // Second source operand
  input wire logic bit_in, // Addressed bit value
  output logic instr_ready, // Free to take a class
  output logic decode_valid, // Length and base states valid
  output logic [2:0] instr_len, // Length in bytes
  output logic [3:0] base_states, // Base (not taken) state count
  output logic exec_done, // Execution finished
  output logic branch_taken, // Condition held
  output logic [mbd_pkg::PC_W-1:0] next_pc, // Following instruction address
  output logic carry_flag, // Carry flag
  output logic bit_we, // Write bit_val to the bit
  output logic bit_val, // Value for the bit
  output logic result_we, // Write result
  output logic [mbd_pkg::DATA_W-1:0] result, // Result word
  output logic illegal_op // Class not recognised
);
  import mbd_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_RUN} mbd_seq_t;

  typedef struct packed {
    mbd_seq_t st;
    logic ready;
    logic dec_valid;
    logic [2:0] len;
    logic [3:0] base;
    logic done;
    logic taken;
    logic [PC_W-1:0] npc;
    logic carry;
    logic bwe;
    logic bval;
    logic rwe;
    logic [DATA_W-1:0] res;
    logic illegal;
    logic tstart;
    logic [CNT_W-1:0] tstates;
    mbd_op_t op;
    mbd_tgt_t tgt;
    logic mode;
    logic [PC_W-1:0] pc;
    logic [7:0] rel;
    logic [7:0] acc;
    logic [OPND_W-1:0] a;
    logic [OPND_W-1:0] b;
    logic bit_v;
  } mbd_state_t;

  mbd_state_t s, next_s;
  mbd_row_t row;
  logic [2:0] len_m;
  logic [4:0] base_m;
  logic [4:0] extra;
  logic [4:0] total;

  mbd_exec_if x ();

  // Operands reach the helpers from the captured copy
  assign x.op = s.op;
  assign x.carry = s.carry;
  assign x.bit_in = s.bit_v;
  assign x.acc = s.acc;
  assign x.opnd_a = s.a;
  assign x.opnd_b = s.b;
  assign x.start = s.tstart;
  assign x.states = s.tstates;

  mbd_bit_alu u_alu (
    .x (x.alu)
  );

  mbd_state_timer #(
    .CLKS (CLK_PER_STATE)
  ) u_timer (
    .clk (clk),
    .resetn (resetn),
    .t (x.timer)
  );

  // Timing table, binary-mode figures; zero bytes marks an unknown class
  function automatic mbd_row_t row_of(input mbd_op_t op);
    mbd_row_t r;
    r = '0;
    unique case (op)
      OP_MV_B, OP_MV_W: r = '{3'h3, 4'h2, ADJ_LESS, 1'b0, EX_NONE};
      OP_MV_D: r = '{3'h3, 4'h3, ADJ_LESS, 1'b0, EX_NONE};
      OP_IMM_B: r = '{3'h4, 4'h3, ADJ_LESS, 1'b0, EX_NONE};
      OP_IMM_W: r = '{3'h5, 4'h3, ADJ_LESS, 1'b0, EX_NONE};
      OP_IMM_DZ, OP_IMM_DO: r = '{3'h5, 4'h5, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDS_B: r = '{3'h4, 4'h3, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDS_W: r = '{3'h4, 4'h4, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDS_D: r = '{3'h4, 4'h6, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDL_B: r = '{3'h5, 4'h3, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDL_W: r = '{3'h5, 4'h4, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDL_D: r = '{3'h5, 4'h6, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDI_BW: r = '{3'h4, 4'h3, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDI_BD, OP_LDI_WW: r = '{3'h4, 4'h4, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDI_WD: r = '{3'h4, 4'h5, ADJ_LESS, 1'b0, EX_NONE};
      OP_STS_B: r = '{3'h4, 4'h4, ADJ_LESS, 1'b0, EX_NONE};
      OP_STS_W: r = '{3'h4, 4'h5, ADJ_LESS, 1'b0, EX_NONE};
      OP_STS_D: r = '{3'h4, 4'h7, ADJ_LESS, 1'b0, EX_NONE};
      OP_STL_B: r = '{3'h5, 4'h4, ADJ_LESS, 1'b0, EX_NONE};
      OP_STL_W: r = '{3'h5, 4'h5, ADJ_LESS, 1'b0, EX_NONE};
      OP_STL_D: r = '{3'h5, 4'h7, ADJ_LESS, 1'b0, EX_NONE};
      OP_STI_BW: r = '{3'h4, 4'h4, ADJ_LESS, 1'b0, EX_NONE};
      OP_STI_BD, OP_STI_WW: r = '{3'h4, 4'h5, ADJ_LESS, 1'b0, EX_NONE};
      OP_STI_WD: r = '{3'h4, 4'h6, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDX_BW: r = '{3'h5, 4'h6, ADJ_LESS, 1'b0, EX_NONE};
      OP_LDX_WW, OP_LDX_BD: r = '{3'h5, 4'h7, ADJ_LESS, 1'b0, EX_NONE};
      // Carry and bit set, clear, complement
      OP_CF_CLEAR, OP_CF_SET, OP_CF_INV:
        r = '{3'h1, 4'h1, ADJ_SAME, 1'b0, EX_NONE};
      OP_BIT0_L, OP_BIT1_L, OP_BITN_L:
        r = '{3'h2, 4'h2, ADJ_SAME, 1'b0, EX_BIT_WR};
      OP_BIT0_X, OP_BIT1_X, OP_BITN_X:
        r = '{3'h4, 4'h4, ADJ_LESS, 1'b0, EX_BIT_WR};
      OP_AND_L, OP_ANDN_L, OP_OR_L, OP_ORN_L, OP_B2C_L:
        r = '{3'h2, 4'h1, ADJ_SAME, 1'b0, EX_BIT_RD};
      OP_AND_X, OP_ANDN_X, OP_OR_X, OP_ORN_X, OP_B2C_X:
        r = '{3'h4, 4'h3, ADJ_LESS, 1'b0, EX_BIT_RD};
      OP_C2B_L: r = '{3'h2, 4'h2, ADJ_SAME, 1'b0, EX_BIT_WR};
      OP_C2B_X: r = '{3'h4, 4'h4, ADJ_LESS, 1'b0, EX_BIT_WR};
      OP_BR_ZERO, OP_BR_NZERO: r = '{3'h2, 4'h2, ADJ_SAME, 1'b1, EX_NONE};
      OP_BR_HI_L, OP_BR_LO_L: r = '{3'h3, 4'h2, ADJ_SAME, 1'b1, EX_BIT_RD};
      OP_BR_HI_X, OP_BR_LO_X: r = '{3'h5, 4'h4, ADJ_LESS, 1'b1, EX_BIT_RD};
      OP_BR_TC_L: r = '{3'h3, 4'h4, ADJ_SAME, 1'b1, EX_BIT_WR};
      OP_BR_TC_X: r = '{3'h5, 4'h7, ADJ_LESS, 1'b1, EX_BIT_WR};
      OP_BR_CMP: r = '{3'h3, 4'h2, ADJ_MORE, 1'b1, EX_NONE};
      OP_BR_DEC_R: r = '{3'h2, 4'h2, ADJ_MORE, 1'b1, EX_NONE};
      OP_BR_DEC_D: r = '{3'h3, 4'h3, ADJ_SAME, 1'b1, EX_DEC_IO};
      default: r = '0;
    endcase
    return r;
  endfunction

  // Mode-adjusted length and state count of the captured class
  always_comb begin
    row = row_of(s.op);
    len_m = row.bytes;
    base_m = {1'b0, row.states};
    if (s.mode && row.adj == ADJ_LESS) begin
      len_m = row.bytes - 3'h1;
      base_m = {1'b0, row.states} - 5'h01;
    end else if (s.mode && row.adj == ADJ_MORE) begin
      len_m = row.bytes + 3'h1;
      base_m = {1'b0, row.states} + 5'h01;
    end
  end

  // Penalty for slow operand spaces; the datapath names the space
  always_comb begin
    extra = 5'h00;
    unique case (row.ext)
      EX_BIT_RD: begin
        if (s.tgt == TGT_IO) extra = IO_RD_EXTRA;
        else if (s.tgt == TGT_SFR) extra = SFR_RD_EXTRA;
      end
      EX_BIT_WR: begin
        if (s.tgt == TGT_IO) extra = IO_WR_EXTRA;
        else if (s.tgt == TGT_SFR) extra = SFR_WR_EXTRA;
      end
      // Direct decrement on an I/O port
      EX_DEC_IO: begin
        if (s.tgt == TGT_IO) extra = IO_DEC_EXTRA;
      end
      default: extra = 5'h00;
    endcase
    total = base_m + extra;
    // Taken branches cost three more states
    if (row.branch && x.cond) total = total + TAKEN_EXTRA;
  end

  // Sequencer: capture, evaluate and start the timer, then commit
  always_comb begin
    next_s = s;
    next_s.dec_valid = 1'b0;
    next_s.done = 1'b0;
    next_s.tstart = 1'b0;
    next_s.bwe = 1'b0;
    next_s.rwe = 1'b0;
    unique case (s.st)
      ST_IDLE: begin
        if (instr_valid) begin
          next_s.ready = 1'b0;
          next_s.op = op_class;
          next_s.tgt = target_kind;
          next_s.mode = src_mode;
          next_s.pc = pc_in;
          next_s.rel = rel_in;
          next_s.acc = acc_in;
          next_s.a = opnd_a;
          next_s.b = opnd_b;
          next_s.bit_v = bit_in;
          next_s.st = ST_EVAL;
        end
      end
      ST_EVAL: begin
        if (row.bytes == 3'h0) begin
          // Unknown class: flag it and free the port at once
          next_s.illegal = 1'b1;
          next_s.done = 1'b1;
          next_s.taken = 1'b0;
          next_s.npc = s.pc;
          next_s.ready = 1'b1;
          next_s.st = ST_IDLE;
        end else begin
          next_s.illegal = 1'b0;
          next_s.dec_valid = 1'b1;
          next_s.len = len_m;
          next_s.base = base_m[3:0];
          // Advance by length, add offset if taken
          next_s.taken = row.branch && x.cond;
          next_s.npc = s.pc + PC_W'(len_m);
          if (row.branch && x.cond) begin
            next_s.npc = s.pc + PC_W'(len_m) + {{(PC_W - 8){s.rel[7]}}, s.rel};
          end
          // Timer spends two clocks per state
          next_s.tstart = 1'b1;
          next_s.tstates = total;
          next_s.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (x.done) begin
          next_s.done = 1'b1;
          next_s.bwe = x.bit_we;
          next_s.bval = x.bit_out;
          next_s.rwe = x.res_we;
          next_s.res = x.res;
          if (x.carry_we) next_s.carry = x.carry_out;
          next_s.ready = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
    endcase
  end

  // Ready stands high from reset on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.ready <= 1'b1;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a flip-flop of the state record
  assign instr_ready = s.ready;
  assign decode_valid = s.dec_valid;
  assign instr_len = s.len;
  assign base_states = s.base;
  assign exec_done = s.done;
  assign branch_taken = s.taken;
  assign next_pc = s.npc;
  assign carry_flag = s.carry;
  assign bit_we = s.bwe;
  assign bit_val = s.bval;
  assign result_we = s.rwe;
  assign result = s.res;
  assign illegal_op = s.illegal;
endmodule

// file: tb/mbd_checker.sv
// Purpose: port-level timing and result checks
// Assumes: one clock domain, reset active low
// Notes: keeps each accepted class to judge later outputs
`timescale 1ns/1ns
module mbd_checker (
  input wire logic clk, resetn, src_mode, instr_valid, instr_ready, decode_valid, exec_done,
  input wire logic branch_taken, carry_flag, bit_we, result_we, illegal_op,
  input wire mbd_pkg::mbd_op_t op_class,
  input wire mbd_pkg::mbd_tgt_t target_kind,
  input wire logic [mbd_pkg::PC_W-1:0] pc_in, next_pc,
  input wire logic [7:0] rel_in,
  input wire logic [mbd_pkg::OPND_W-1:0] opnd_a, opnd_b,
  input wire logic [2:0] instr_len,
  input wire logic [3:0] base_states,
  input wire logic [mbd_pkg::DATA_W-1:0] result
);
  import mbd_pkg::*;
  logic [6:0] cop;
  logic [1:0] ctg;
  logic cm;
  logic [PC_W-1:0] cpc;
  logic [7:0] crel, ca, cb;
  logic [5:0] cnt;
  logic acc;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  assign acc = instr_valid && instr_ready;
  // Capture the taken class; count clocks since decode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {cop, ctg, cm, cpc, crel, ca, cb} <= '0;
      cnt <= '0;
    end else begin
      if (acc) begin
        {cop, ctg, cm, cpc, crel, ca, cb} <= {op_class, target_kind, src_mode, pc_in,
          rel_in, opnd_a[7:0], opnd_b[7:0]};
      end
      cnt <= decode_valid ? 6'h01 : cnt + 6'h01;
    end
  end
  property p_dv; acc && op_class <= OP_BR_DEC_D |-> ##1 !instr_ready ##1 decode_valid; endproperty
  a_dv: assert property (p_dv) else $error("decode answer late");
  property p_ill; acc && op_class > OP_BR_DEC_D |-> ##2 exec_done && illegal_op; endproperty
  a_ill: assert property (p_ill) else $error("unknown class not flagged");
  property p_mvb;
    decode_valid && cop == OP_MV_B |-> instr_len == (cm ? 3'h2 : 3'h3)
      && base_states == (cm ? 4'h1 : 4'h2);
  endproperty
  a_mvb: assert property (p_mvb) else $error("byte move timing");
  property p_dimm;
    decode_valid && (cop == OP_IMM_DZ || cop == OP_IMM_DO) |-> instr_len == (cm ? 3'h4 : 3'h5)
      && base_states == (cm ? 4'h4 : 4'h5);
  endproperty
  a_dimm: assert property (p_dimm) else $error("dword immediate timing");
  property p_std; decode_valid && cop == OP_STS_D |-> base_states == (cm ? 4'h6 : 4'h7); endproperty
  a_std: assert property (p_std) else $error("dword store timing");
  property p_tim;
    exec_done && !illegal_op && ctg == TGT_MEM |->
      cnt == {1'b0, base_states, 1'b0} + (branch_taken ? 6'h06 : 6'h00) + 6'h02;
  endproperty
  a_tim: assert property (p_tim) else $error("state count mismatch");
  property p_pc;
    exec_done && !illegal_op |-> next_pc == cpc + {21'h0, instr_len}
      + (branch_taken ? {{16{crel[7]}}, crel} : 24'h0);
  endproperty
  a_pc: assert property (p_pc) else $error("next address wrong");
  property p_we; result_we || bit_we |-> exec_done; endproperty
  a_we: assert property (p_we) else $error("write outside completion");
  property p_cy; resetn && $changed(carry_flag) |-> exec_done; endproperty
  a_cy: assert property (p_cy) else $error("carry moved early");
  property p_cmp;
    exec_done && cop == OP_BR_CMP && !illegal_op |-> carry_flag == (ca < cb)
      && branch_taken == (ca != cb);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare branch result");
  property p_ones; result_we && cop == OP_IMM_DO |-> result[31:16] == UPPER_ONES; endproperty
  a_ones: assert property (p_ones) else $error("upper half not ones");
  c_taken: cover property (exec_done && branch_taken);
  c_bit: cover property (exec_done && bit_we);
  c_ill: cover property (exec_done && illegal_op);
  c_src: cover property (decode_valid && cm);
endmodule
bind mbd_decoder mbd_checker u_chk (.*);

// file: tb/mbd_feed.sv
// Purpose: prefetch queue model presenting one class at a time
// Assumes: send is a one-cycle pulse while the decoder is idle
// Notes: fields are scrambled once taken, so a late sample shows up
`timescale 1ns/1ns
module mbd_feed (
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic send, // Present a new class
  input wire mbd_pkg::mbd_op_t op, // Class to present
  input wire mbd_pkg::mbd_tgt_t tgt, // Operand space
  input wire logic [15:0] a, // First operand
  input wire logic instr_ready, // Decoder free
  output logic instr_valid, // Class presented
  output mbd_pkg::mbd_op_t op_class, // Held class
  output mbd_pkg::mbd_tgt_t target_kind, // Held space
  output logic [15:0] opnd_a // Held operand
);
  import mbd_pkg::*;
  // Hold until taken, then invert so a stale class never looks valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instr_valid <= 1'b0;
      op_class <= OP_MV_B;
      target_kind <= TGT_MEM;
      opnd_a <= '0;
    end else if (send) begin
      instr_valid <= 1'b1;
      op_class <= op;
      target_kind <= tgt;
      opnd_a <= a;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      op_class <= mbd_op_t'(~op_class);
      target_kind <= mbd_tgt_t'(~target_kind);
      opnd_a <= ~opnd_a;
    end
  end
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the move/bit/branch decoder
// Assumes: 100 MHz clock, inputs changed on the rising edge
// Notes: expected figures are written out per class
`timescale 1ns/1ns
module tb_top;
  import mbd_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, src_mode = 1'b0, bit_in = 1'b0, send = 1'b0;
  logic [PC_W-1:0] pc_in = 24'h001000;
  logic [7:0] rel_in = 8'h10, acc_in = 8'h00;
  logic [15:0] opnd_b = 16'h0000, p_a = 16'h0000, opnd_a;
  mbd_op_t p_op = OP_MV_B, op_class;
  mbd_tgt_t p_tgt = TGT_MEM, target_kind;
  logic instr_valid, instr_ready, decode_valid, exec_done, branch_taken, carry_flag;
  logic bit_we, bit_val, result_we, illegal_op;
  logic [2:0] instr_len;
  logic [3:0] base_states;
  logic [PC_W-1:0] next_pc;
  logic [DATA_W-1:0] result;
  int bad_count = 0, compares = 0;
  mbd_decoder dut (.*);
  mbd_feed feed (.clk(clk), .resetn(resetn), .send(send), .op(p_op), .tgt(p_tgt), .a(p_a),
    .instr_ready(instr_ready), .instr_valid(instr_valid), .op_class(op_class),
    .target_kind(target_kind), .opnd_a(opnd_a));
  // Free-running core clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Present one class; judge length, states, clocks to done and next address
  task automatic run(mbd_op_t o, mbd_tgt_t k, logic m, logic [15:0] a, logic [2:0] el,
    logic [3:0] eb, int et, logic tk);
    int n;
    @(posedge clk);
    p_op <= o;
    p_tgt <= k;
    {src_mode, p_a, send} <= {m, a, 1'b1};
    @(posedge clk);
    send <= 1'b0;
    #1 n = 0;
    while (decode_valid !== 1'b1 && n < 40) begin @(posedge clk); #1 n++; end
    chk(instr_len, el);
    chk(base_states, eb);
    n = 0;
    while (exec_done !== 1'b1 && n < 60) begin @(posedge clk); #1 n++; end
    chk(n, 2 * et + 2);
    chk(branch_taken, tk);
    chk(next_pc, PC_W'(pc_in + el + (tk ? {{16{rel_in[7]}}, rel_in} : 24'h0)));
  endtask
  task automatic t_moves();
    mbd_op_t ops [13] = '{OP_MV_B, OP_MV_D, OP_IMM_B, OP_IMM_W, OP_IMM_DZ, OP_IMM_DO,
      OP_LDS_D, OP_LDL_W, OP_LDI_WD, OP_STS_D, OP_STL_B, OP_STI_WD, OP_LDX_BD};
    logic [2:0] ln [13] = '{3,3,4,5,5,5,4,5,4,4,5,4,5};
    logic [3:0] st [13] = '{2,3,3,3,5,5,6,4,5,7,4,6,7};
    // Both modes back to back, source one byte and one state less
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 13; i++) begin
        run(ops[i], TGT_MEM, m[0], {12'h5A3, i[3:0]}, 3'(ln[i] - m), 4'(st[i] - m),
          st[i] - m, 1'b0);
        chk(result_we, 1'b1);
        chk(result, {(ops[i] == OP_IMM_DO) ? 16'hFFFF : 16'h0000, 12'h5A3, i[3:0]});
      end
    end
  endtask
  task automatic t_bits();
    run(OP_CF_SET, TGT_MEM, 1'b1, 16'h0, 3'h1, 4'h1, 1, 1'b0);
    chk(carry_flag, 1'b1);
    run(OP_CF_INV, TGT_MEM, 1'b0, 16'h0, 3'h1, 4'h1, 1, 1'b0);
    chk(carry_flag, 1'b0);
    run(OP_BIT1_L, TGT_IO, 1'b0, 16'h0, 3'h2, 4'h2, 4, 1'b0);
    chk({bit_we, bit_val}, 2'b11);
    run(OP_BITN_X, TGT_SFR, 1'b1, 16'h0, 3'h3, 4'h3, 6, 1'b0);
    @(posedge clk) bit_in <= 1'b1;
    run(OP_OR_L, TGT_IO, 1'b0, 16'h0, 3'h2, 4'h1, 2, 1'b0);
    chk(carry_flag, 1'b1);
    run(OP_ANDN_X, TGT_SFR, 1'b1, 16'h0, 3'h3, 4'h2, 4, 1'b0);
    chk(carry_flag, 1'b0);
    run(OP_C2B_X, TGT_MEM, 1'b0, 16'h0, 3'h4, 4'h4, 4, 1'b0);
    chk({bit_we, bit_val}, 2'b10);
    run(OP_B2C_X, TGT_MEM, 1'b1, 16'h0, 3'h3, 4'h2, 2, 1'b0);
    chk(carry_flag, 1'b1);
  endtask
  task automatic t_branches();
    @(posedge clk) {pc_in, rel_in, acc_in, opnd_b} <= {24'h00F0F0, 8'hF0, 8'h00, 16'h0009};
    run(OP_BR_ZERO, TGT_MEM, 1'b0, 16'h0, 3'h2, 4'h2, 5, 1'b1);
    run(OP_BR_NZERO, TGT_MEM, 1'b1, 16'h0, 3'h2, 4'h2, 2, 1'b0);
    run(OP_BR_TC_X, TGT_MEM, 1'b0, 16'h0, 3'h5, 4'h7, 10, 1'b1);
    chk({bit_we, bit_val}, 2'b10);
    run(OP_BR_TC_L, TGT_SFR, 1'b1, 16'h0, 3'h3, 4'h4, 10, 1'b1);
    run(OP_BR_HI_X, TGT_IO, 1'b1, 16'h0, 3'h4, 4'h3, 7, 1'b1);
    run(OP_BR_CMP, TGT_MEM, 1'b0, 16'h0005, 3'h3, 4'h2, 5, 1'b1);
    chk(carry_flag, 1'b1);
    run(OP_BR_DEC_D, TGT_IO, 1'b0, 16'h0001, 3'h3, 4'h3, 5, 1'b0);
    run(OP_BR_DEC_R, TGT_MEM, 1'b0, 16'h0003, 3'h2, 4'h2, 5, 1'b1);
  endtask
  task automatic t_illegal();
    @(posedge clk);
    p_op <= mbd_op_t'(7'h7F);
    send <= 1'b1;
    @(posedge clk) send <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(illegal_op, 1'b1);
    run(OP_MV_W, TGT_MEM, 1'b1, 16'h0, 3'h2, 4'h1, 1, 1'b0);
    chk(illegal_op, 1'b0);
  endtask
  task automatic t_reset();
    @(posedge clk);
    p_op <= OP_STS_D;
    send <= 1'b1;
    @(posedge clk) send <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk) chk({instr_ready, decode_valid, exec_done, carry_flag}, 4'h8);
    @(posedge clk) resetn <= 1'b1;
  endtask
  // Hang guard, far past the expected run length
  initial begin
    #300000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_moves();
    t_bits();
    t_branches();
    t_illegal();
    t_reset();
    run(OP_MV_B, TGT_MEM, 1'b0, 16'h0042, 3'h3, 4'h2, 2, 1'b0);
    close_out();
  end
endmodule
